//--- pkg/drive_fault_supervisor_pkg.sv
// constants shared by the drive fault supervisor design
package drive_fault_supervisor_pkg;
  // ******************************************************************
  // register map (byte addresses)
  // ******************************************************************
  localparam int unsigned NUM_CFG = 7;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OVERHEAT = 8'h04;
  localparam logic [7:0] OFS_OFFLOAD = 8'h08;
  localparam logic [7:0] OFS_OVERSPEED = 8'h0c;
  localparam logic [7:0] OFS_DEVIATION = 8'h10;
  localparam logic [7:0] OFS_STANDBY = 8'h14;
  localparam logic [7:0] OFS_ACTION = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_TEMP_MON = 8'h20;
  localparam logic [7:0] OFS_LAST_CFG = 8'h18;

  // ******************************************************************
  // writable bits and values after reset, indexed by offset / 4
  // ******************************************************************
  localparam logic [31:0] CFG_MASK [NUM_CFG] = '{32'h0000_0007, 32'h0000_ffff,
    32'h03ff_03ff, 32'h03ff_03ff, 32'h03ff_03ff, 32'h0000_03ff, 32'h0000_007f};
  // sensor none, protect off; warn 90 / fault 110 degC; offload 1.0 s / 10.0 %;
  // overspeed 1.0 s / 20.0 %; deviation 5.0 s / 20.0 %; standby 100.0 %; actions 0
  localparam logic [31:0] CFG_RESET [NUM_CFG] = '{32'h0000_0000, 32'h0000_5a6e,
    32'h000a_0064, 32'h000a_00c8, 32'h0032_00c8, 32'h0000_03e8, 32'h0000_0000};

  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int unsigned SENSOR_LSB = 0;
  localparam int unsigned OFFLOAD_EN_BIT = 2;
  localparam int unsigned FAULT_THR_LSB = 0;
  localparam int unsigned WARN_THR_LSB = 8;
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned TIME_LSB = 16;
  localparam int unsigned ACT_DEV_LSB = 0;
  localparam int unsigned ACT_OS_LSB = 2;
  localparam int unsigned CONT_SEL_LSB = 4;
  localparam int unsigned ST_OVERHEAT = 0;
  localparam int unsigned ST_WARN = 1;
  localparam int unsigned ST_OFFLOAD = 2;
  localparam int unsigned ST_OVERSPEED = 3;
  localparam int unsigned ST_DEVIATION = 4;

  // ******************************************************************
  // codes
  // ******************************************************************
  typedef enum logic [1:0] {SENSOR_NONE = 2'b00, SENSOR_PT100 = 2'b01, SENSOR_PT1000 = 2'b10} sensor_e;
  typedef enum logic [1:0] {ACT_COAST = 2'b00, ACT_RAMP = 2'b01, ACT_CONTINUE = 2'b10} action_e;
  localparam logic [2:0] CONT_RUN_FREQ = 3'h0;
  localparam logic [2:0] CONT_SET_FREQ = 3'h1;
  localparam logic [2:0] CONT_UPPER = 3'h2;
  localparam logic [2:0] CONT_LOWER = 3'h3;
  localparam logic [2:0] CONT_STANDBY = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ******************************************************************
  // scaling and timing
  // ******************************************************************
  localparam int unsigned PER_MILLE = 1000;
  localparam int unsigned OFFLOAD_FREQ_PCT = 7;
  localparam int unsigned PERCENT = 100;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TIME_UNIT_NS = 100_000_000;
  localparam int unsigned TIME_UNIT_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned TIME_W = 10;
endpackage

//--- core/persist_timer.sv
// persistence timer: trips once a condition has held longer than a limit
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
  parameter int unsigned CNT_W = 10,
  parameter bit ZERO_DISABLES = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic cond_in,
  input wire logic [CNT_W-1:0] limit_in,
  output logic trip_out
);
  logic [CNT_W-1:0] cnt_r;

  // ******************************************************************
  // count ticks while the condition stands
  // ******************************************************************
  // trip needs limit+1 ticks so the duration is strictly longer than the limit
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !cond_in || (ZERO_DISABLES && limit_in == '0))
    begin
      cnt_r <= '0; // R15 R9 R11
      trip_out <= 1'b0;
    end
    else if (tick_in && !trip_out)
    begin
      if (cnt_r == limit_in)
        trip_out <= 1'b1;
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- core/drive_fault_supervisor.sv
// drive fault supervisor: temperature, off-load, overspeed and deviation checks
// Function
// R1: a sensor type field holds 0 none, 1 PT100 class, 2 PT1000 class, reset 0.
// R2: the measured motor temperature is readable in a read-only monitor register.
// R3: temperature above the overheat threshold (0..200 degC, reset 110) raises a fault; the code accepts thresholds up to 255.
// R4: temperature above the warning threshold (0..200 degC, reset 90) drives the warning output; the code accepts thresholds up to 255.
// R5: a one-bit off-load protection enable resets to 0.
// R6: when enabled, current below the level longer than the time cuts frequency to 7 % of rated.
// R7: the off-load cut ends as soon as the current recovers.
// R8: speed above max frequency by more than the margin longer than the time raises overspeed.
// R9: an overspeed time of zero disables overspeed detection.
// R10: speed off the set frequency by more than the margin longer than the time raises deviation.
// R11: a deviation time of zero disables deviation detection.
// R12: a standby frequency of 0..100 % of max frequency resets to 100 %; the code accepts up to 1023 per mille (102.3 %).
// R13: a continue-running fault with selection 4 runs at the standby frequency.
// R14: deviation uses the units action digit and overspeed the tens: coast, ramp stop, continue.
// R15: each persistence timer restarts whenever its condition clears early.
`timescale 1ns/1ps
`default_nettype none
module drive_fault_supervisor #(
  parameter int unsigned TIME_UNIT_CYCLES = drive_fault_supervisor_pkg::TIME_UNIT_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [7:0] motor_temp_in,
  input wire logic [9:0] output_current_in,
  input wire logic [15:0] motor_speed_in,
  input wire logic [15:0] set_freq_in,
  input wire logic [15:0] run_freq_in,
  input wire logic [15:0] max_freq_in,
  input wire logic [15:0] upper_freq_in,
  input wire logic [15:0] lower_freq_in,
  input wire logic [15:0] rated_freq_in,
  output logic overheat_warning_out,
  output logic overheat_fault_out,
  output logic overspeed_fault_out,
  output logic speed_deviation_fault_out,
  output logic stop_coast_out,
  output logic stop_ramp_out,
  output logic freq_override_out,
  output logic [15:0] freq_cmd_out
);
  if (TIME_UNIT_CYCLES < 2)
  begin : g_bad_time
    $error("TIME_UNIT_CYCLES must be at least 2");
  end

  // ******************************************************************
  // helpers
  // ******************************************************************
  // byte-lane merge limited to the writable bits of a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
    input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    merge = res & mask;
  endfunction

  // fraction in per mille of a frequency, saturated to 16 bits
  function automatic logic [15:0] scale(input logic [15:0] f, input logic [9:0] pm);
    logic [25:0] prod;
    prod = 26'(f * pm) / 26'(drive_fault_supervisor_pkg::PER_MILLE);
    scale = (prod > 26'h00_ffff) ? 16'hffff : prod[15:0];
  endfunction

  // ******************************************************************
  // register storage and bus state
  // ******************************************************************
  logic [31:0] cfg_r [drive_fault_supervisor_pkg::NUM_CFG];
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic [2:0] widx;
  logic wr_mapped;
  logic clr_overheat;
  logic clr_overspeed;
  logic clr_deviation;
  logic [7:0] temp_mon_r;
  logic offload_active_r;

  assign widx = awaddr_r[4:2];
  assign wr_mapped = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= drive_fault_supervisor_pkg::OFS_LAST_CFG);
  assign do_write = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  assign clr_overheat = do_write && awaddr_r == drive_fault_supervisor_pkg::OFS_STATUS && wstrb_r[0]
    && wdata_r[drive_fault_supervisor_pkg::ST_OVERHEAT];
  assign clr_overspeed = do_write && awaddr_r == drive_fault_supervisor_pkg::OFS_STATUS && wstrb_r[0]
    && wdata_r[drive_fault_supervisor_pkg::ST_OVERSPEED];
  assign clr_deviation = do_write && awaddr_r == drive_fault_supervisor_pkg::OFS_STATUS && wstrb_r[0]
    && wdata_r[drive_fault_supervisor_pkg::ST_DEVIATION];

  // write address and data taken independently, one write at a time
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= drive_fault_supervisor_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        awaddr_r <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (wr_mapped || awaddr_r == drive_fault_supervisor_pkg::OFS_STATUS)
          ? drive_fault_supervisor_pkg::RESP_OKAY : drive_fault_supervisor_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // configuration registers, one generated word each
  for (genvar g = 0; g < drive_fault_supervisor_pkg::NUM_CFG; g++)
  begin : g_cfg
    always_ff @(posedge mclk_in)
    begin
      if (rst_in)
        cfg_r[g] <= drive_fault_supervisor_pkg::CFG_RESET[g]; // R1 R5 R12
      else if (do_write && wr_mapped && widx == 3'(g))
        cfg_r[g] <= merge(cfg_r[g], wdata_r, wstrb_r, drive_fault_supervisor_pkg::CFG_MASK[g]);
    end
  end

  // ******************************************************************
  // field views
  // ******************************************************************
  logic [1:0] sensor_sel;
  logic offload_en;
  logic [7:0] fault_thr;
  logic [7:0] warn_thr;
  logic [9:0] offload_level;
  logic [9:0] offload_time;
  logic [9:0] os_margin;
  logic [9:0] os_time;
  logic [9:0] dv_margin;
  logic [9:0] dv_time;
  logic [9:0] standby_pm;
  logic [1:0] act_dev;
  logic [1:0] act_os;
  logic [2:0] cont_sel;

  assign sensor_sel = cfg_r[0][drive_fault_supervisor_pkg::SENSOR_LSB +: 2];
  assign offload_en = cfg_r[0][drive_fault_supervisor_pkg::OFFLOAD_EN_BIT]; // R5
  assign fault_thr = cfg_r[1][drive_fault_supervisor_pkg::FAULT_THR_LSB +: 8];
  assign warn_thr = cfg_r[1][drive_fault_supervisor_pkg::WARN_THR_LSB +: 8];
  assign offload_level = cfg_r[2][drive_fault_supervisor_pkg::LEVEL_LSB +: 10];
  assign offload_time = cfg_r[2][drive_fault_supervisor_pkg::TIME_LSB +: 10];
  assign os_margin = cfg_r[3][drive_fault_supervisor_pkg::LEVEL_LSB +: 10];
  assign os_time = cfg_r[3][drive_fault_supervisor_pkg::TIME_LSB +: 10];
  assign dv_margin = cfg_r[4][drive_fault_supervisor_pkg::LEVEL_LSB +: 10];
  assign dv_time = cfg_r[4][drive_fault_supervisor_pkg::TIME_LSB +: 10];
  assign standby_pm = cfg_r[5][9:0];
  assign act_dev = cfg_r[6][drive_fault_supervisor_pkg::ACT_DEV_LSB +: 2]; // R14
  assign act_os = cfg_r[6][drive_fault_supervisor_pkg::ACT_OS_LSB +: 2]; // R14
  assign cont_sel = cfg_r[6][drive_fault_supervisor_pkg::CONT_SEL_LSB +: 3];

  // ******************************************************************
  // read channel
  // ******************************************************************
  logic [7:0] raddr;
  logic [31:0] status_word;

  assign raddr = s_axi_araddr_in;
  assign status_word = {27'h0, speed_deviation_fault_out, overspeed_fault_out, offload_active_r,
    overheat_warning_out, overheat_fault_out};

  // one read at a time; data sampled with the address
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= drive_fault_supervisor_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= drive_fault_supervisor_pkg::RESP_OKAY;
      if (raddr[1:0] == 2'b00 && raddr <= drive_fault_supervisor_pkg::OFS_LAST_CFG)
        s_axi_rdata_out <= cfg_r[raddr[4:2]];
      else if (raddr == drive_fault_supervisor_pkg::OFS_STATUS)
        s_axi_rdata_out <= status_word;
      else if (raddr == drive_fault_supervisor_pkg::OFS_TEMP_MON)
        s_axi_rdata_out <= {24'h0, temp_mon_r}; // R2
      else
      begin
        s_axi_rdata_out <= 32'h0000_0000;
        s_axi_rresp_out <= drive_fault_supervisor_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ******************************************************************
  // temperature supervision
  // ******************************************************************
  // with no sensor fitted the reading is meaningless, so it shows zero
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      temp_mon_r <= 8'h00;
    else if (sensor_sel == drive_fault_supervisor_pkg::SENSOR_NONE)
      temp_mon_r <= 8'h00; // R1
    else
      temp_mon_r <= motor_temp_in; // R2
  end

  // warning follows the temperature, the fault latches until cleared; set beats clear
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      overheat_warning_out <= 1'b0;
      overheat_fault_out <= 1'b0;
    end
    else
    begin
      overheat_warning_out <= (sensor_sel != drive_fault_supervisor_pkg::SENSOR_NONE)
        && (temp_mon_r > warn_thr); // R4
      if ((sensor_sel != drive_fault_supervisor_pkg::SENSOR_NONE) && temp_mon_r > fault_thr)
        overheat_fault_out <= 1'b1; // R3
      else if (clr_overheat)
        overheat_fault_out <= 1'b0;
    end
  end

  // ******************************************************************
  // time base and persistence timers
  // ******************************************************************
  logic [31:0] tick_cnt_r;
  logic tick_r;

  // one tick per 0.1 s shared by all timers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || tick_cnt_r == TIME_UNIT_CYCLES - 1)
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      tick_r <= 1'b0;
    else
      tick_r <= (tick_cnt_r == TIME_UNIT_CYCLES - 1);
  end

  logic [16:0] os_limit;
  logic [15:0] dv_limit;
  logic [16:0] speed_diff;
  logic low_current;
  logic over_speed;
  logic off_speed;
  logic [2:0] trip;

  assign os_limit = {1'b0, max_freq_in} + {1'b0, scale(max_freq_in, os_margin)};
  assign dv_limit = scale(max_freq_in, dv_margin);
  assign speed_diff = (motor_speed_in >= set_freq_in) ? {1'b0, motor_speed_in - set_freq_in}
    : {1'b0, set_freq_in - motor_speed_in};
  assign low_current = offload_en && (output_current_in < offload_level); // R6
  assign over_speed = {1'b0, motor_speed_in} > os_limit; // R8
  assign off_speed = speed_diff > {1'b0, dv_limit}; // R10

  persist_timer #(.CNT_W(drive_fault_supervisor_pkg::TIME_W), .ZERO_DISABLES(1'b0)) u_offload (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .tick_in(tick_r),
    .cond_in(low_current),
    .limit_in(offload_time),
    .trip_out(trip[0])
  );
  persist_timer #(.CNT_W(drive_fault_supervisor_pkg::TIME_W), .ZERO_DISABLES(1'b1)) u_overspeed (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .tick_in(tick_r),
    .cond_in(over_speed),
    .limit_in(os_time),
    .trip_out(trip[1])
  );
  persist_timer #(.CNT_W(drive_fault_supervisor_pkg::TIME_W), .ZERO_DISABLES(1'b1)) u_deviation (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .tick_in(tick_r),
    .cond_in(off_speed),
    .limit_in(dv_time),
    .trip_out(trip[2])
  );

  // speed faults latch; off-load cut drops with the timer once current recovers
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      offload_active_r <= 1'b0;
      overspeed_fault_out <= 1'b0;
      speed_deviation_fault_out <= 1'b0;
    end
    else
    begin
      offload_active_r <= trip[0]; // R6 R7
      if (trip[1])
        overspeed_fault_out <= 1'b1; // R8
      else if (clr_overspeed)
        overspeed_fault_out <= 1'b0;
      if (trip[2])
        speed_deviation_fault_out <= 1'b1; // R10
      else if (clr_deviation)
        speed_deviation_fault_out <= 1'b0;
    end
  end

  // ******************************************************************
  // fault action and frequency command
  // ******************************************************************
  logic coast_nxt;
  logic ramp_nxt;
  logic cont_nxt;
  logic [15:0] cont_freq;

  // a stop request beats continue-running; overheat always coasts
  always_comb
  begin
    coast_nxt = overheat_fault_out
      || (overspeed_fault_out && act_os == drive_fault_supervisor_pkg::ACT_COAST)
      || (speed_deviation_fault_out && act_dev == drive_fault_supervisor_pkg::ACT_COAST); // R14
    ramp_nxt = !coast_nxt && ((overspeed_fault_out && act_os == drive_fault_supervisor_pkg::ACT_RAMP)
      || (speed_deviation_fault_out && act_dev == drive_fault_supervisor_pkg::ACT_RAMP)); // R14
    cont_nxt = !coast_nxt && !ramp_nxt
      && ((overspeed_fault_out && act_os == drive_fault_supervisor_pkg::ACT_CONTINUE)
      || (speed_deviation_fault_out && act_dev == drive_fault_supervisor_pkg::ACT_CONTINUE));
    case (cont_sel)
      drive_fault_supervisor_pkg::CONT_RUN_FREQ: cont_freq = run_freq_in;
      drive_fault_supervisor_pkg::CONT_SET_FREQ: cont_freq = set_freq_in;
      drive_fault_supervisor_pkg::CONT_UPPER: cont_freq = upper_freq_in;
      drive_fault_supervisor_pkg::CONT_LOWER: cont_freq = lower_freq_in;
      drive_fault_supervisor_pkg::CONT_STANDBY: cont_freq = scale(max_freq_in, standby_pm); // R13
      default: cont_freq = run_freq_in;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      stop_coast_out <= 1'b0;
      stop_ramp_out <= 1'b0;
      freq_override_out <= 1'b0;
      freq_cmd_out <= 16'h0000;
    end
    else
    begin
      stop_coast_out <= coast_nxt;
      stop_ramp_out <= ramp_nxt;
      freq_override_out <= cont_nxt || offload_active_r;
      if (cont_nxt)
        freq_cmd_out <= cont_freq; // R13
      else if (offload_active_r)
        freq_cmd_out <= 16'(32'(rated_freq_in) * drive_fault_supervisor_pkg::OFFLOAD_FREQ_PCT
          / drive_fault_supervisor_pkg::PERCENT); // R6
      else
        freq_cmd_out <= set_freq_in; // R7
    end
  end
endmodule
`default_nettype wire

//--- tb/drive_fault_monitor.sv
// checker on the supervisor's bus and fault outputs
`timescale 1ns/1ps
`default_nettype none
module drive_fault_monitor (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_bvalid_out,
  input wire logic overheat_fault_out,
  input wire logic overspeed_fault_out,
  input wire logic speed_deviation_fault_out,
  input wire logic stop_coast_out,
  input wire logic stop_ramp_out,
  input wire logic freq_override_out,
  input wire logic [15:0] freq_cmd_out,
  input wire logic [15:0] set_freq_in,
  input wire logic [15:0] rated_freq_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // any latched fault
  wire logic any_f = overheat_fault_out | overspeed_fault_out | speed_deviation_fault_out;
  property p_r_ans; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  // faults only fall at the write that clears them
  property p_oh; $fell(overheat_fault_out) |-> $rose(s_axi_bvalid_out); endproperty
  a_oh: assert property (p_oh) else $error("overheat fault fell alone");
  property p_os; $fell(overspeed_fault_out) |-> $rose(s_axi_bvalid_out); endproperty
  a_os: assert property (p_os) else $error("overspeed fault fell alone");
  property p_dev; $fell(speed_deviation_fault_out) |-> $rose(s_axi_bvalid_out); endproperty
  a_dev: assert property (p_dev) else $error("deviation fault fell alone");
  property p_stop; stop_coast_out || stop_ramp_out |-> $past(any_f); endproperty
  a_stop: assert property (p_stop) else $error("stop without fault");
  property p_norm; !$past(rst_in) && !freq_override_out && !stop_coast_out && !stop_ramp_out
    |-> freq_cmd_out == $past(set_freq_in); endproperty
  a_norm: assert property (p_norm) else $error("command not set freq");
  property p_cut; freq_override_out && !$past(any_f) |-> freq_cmd_out == $past(rated_freq_in) * 7 / 100;
  endproperty
  a_cut: assert property (p_cut) else $error("off-load freq wrong");
  c_os: cover property ($rose(overspeed_fault_out));
  c_cut: cover property ($rose(freq_override_out) && !any_f);
  c_ramp: cover property ($rose(stop_ramp_out));
endmodule
`default_nettype wire

//--- tb/drive_plant_model.sv
// sensor and power-stage measurement model feeding the supervisor
`timescale 1ns/1ps
`default_nettype none
module drive_plant_model (
  input wire logic mclk_in,
  input wire logic [7:0] temp_set_in,
  input wire logic [9:0] load_set_in,
  input wire logic [15:0] shaft_set_in,
  output logic [7:0] motor_temp_out,
  output logic [9:0] output_current_out,
  output logic [15:0] motor_speed_out
);
  // sensors sample once a cycle, so a step shows one cycle late
  always_ff @(posedge mclk_in)
  begin
    motor_temp_out <= temp_set_in;
    output_current_out <= load_set_in;
    motor_speed_out <= shaft_set_in;
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the drive fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00, temp_set = 8'h00;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic [9:0] load_set = 10'h3e8;
  logic [15:0] shaft_set, set_freq_in, rated_freq_in, max_freq_in = 16'h03e8;
  logic [15:0] run_freq_in = 16'h0, upper_freq_in = 16'h0, lower_freq_in = 16'h0;
  logic [7:0] motor_temp_in;
  logic [9:0] output_current_in;
  logic [15:0] motor_speed_in, freq_cmd_out;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic overheat_warning_out, overheat_fault_out, overspeed_fault_out, speed_deviation_fault_out;
  logic stop_coast_out, stop_ramp_out, freq_override_out;
  int mismatches = 0, checks = 0, cyc = 0, rated;
  integer seed = 32'h25107e35;
  always #5 mclk_in = ~mclk_in;
  // short time unit keeps persistence counts short
  drive_fault_supervisor #(.TIME_UNIT_CYCLES(4)) i_dut (.*);
  drive_plant_model i_plant (.mclk_in(mclk_in), .temp_set_in(temp_set), .load_set_in(load_set),
    .shaft_set_in(shaft_set), .motor_temp_out(motor_temp_in), .output_current_out(output_current_in),
    .motor_speed_out(motor_speed_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    idle(1);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      idle(1);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    chk(32'(s_axi_bresp_out), 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    idle(1);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    do
    begin
      idle(1);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b1;
    idle(1);
    s_axi_rready_in <= 1'b0;
    chk(s_axi_rdata_out, exp);
    chk(32'(s_axi_rresp_out), 32'(er));
  endtask
  // hang guard, far above the run's length
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      mismatches++;
      summarize();
    end
  end
  initial
  begin
    rated = 1000 + ($unsigned($random(seed)) % 4000);
    rated_freq_in = 16'(rated);
    set_freq_in = 16'($unsigned($random(seed)) % 1000);
    shaft_set = set_freq_in;
    idle(4);
    rst_in <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(8'(i * 4), drive_fault_supervisor_pkg::CFG_RESET[i], 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    wr(8'h00, 32'h1);
    temp_set <= 8'd100;
    idle(6);
    rd(8'h20, 32'd100, 2'b00);
    chk({overheat_warning_out, overheat_fault_out}, 2'b10);
    temp_set <= 8'd120;
    idle(6);
    chk({overheat_fault_out, stop_coast_out}, 2'b11);
    temp_set <= 8'd20;
    idle(4);
    wr(8'h1c, 32'h1);
    idle(4);
    chk({overheat_fault_out, overheat_warning_out, stop_coast_out}, 3'b000);
    wr(8'h08, 32'h0002_0064);
    wr(8'h00, 32'h5);
    // dips of two ticks never exceed a limit of two ticks
    for (int i = 0; i < 3; i++)
    begin
      load_set <= 10'd50;
      idle(8);
      load_set <= 10'd500;
      idle(2);
    end
    chk(freq_override_out, 1'b0);
    load_set <= 10'd50;
    idle(20);
    chk({freq_override_out, freq_cmd_out}, {1'b1, 16'(rated * 7 / 100)});
    load_set <= 10'd500;
    idle(5);
    chk({freq_override_out, freq_cmd_out}, {1'b0, set_freq_in});
    wr(8'h00, 32'h1);
    wr(8'h14, 32'd500);
    wr(8'h18, 32'h48);
    wr(8'h0c, 32'h0001_00c8);
    set_freq_in <= 16'd1200;
    shaft_set <= 16'd1300;
    idle(20);
    chk({overspeed_fault_out, freq_override_out, stop_coast_out, freq_cmd_out}, {3'b110, 16'd500});
    shaft_set <= 16'd1200;
    idle(4);
    wr(8'h1c, 32'h8);
    wr(8'h0c, 32'h0000_00c8);
    wr(8'h10, 32'h0001_00c8);
    for (int a = 0; a < 2; a++)
    begin
      wr(8'h18, 32'(a));
      shaft_set <= 16'd1500;
      idle(20);
      chk({overspeed_fault_out, speed_deviation_fault_out, stop_coast_out, stop_ramp_out}, {2'b01, a == 0, a == 1});
      shaft_set <= 16'd1200;
      idle(4);
      wr(8'h1c, 32'h10);
    end
    summarize();
  end
endmodule
bind drive_fault_supervisor drive_fault_monitor i_mon (.*);
`default_nettype wire
